// File: core/pin_edge_detect.v
// Two-stage pin synchroniser with selectable edge detection.
`include "timer_channel_defs.vh"

module pin_edge_detect (
   input wire core_clk,
   input wire rstSync,
   input wire pinIn,
   input wire [1:0] eventSelect,
   output reg edgeSeen
);

   reg syncA;
   reg syncB;
   reg syncPrev;

   // ---------------------------------------------------------------
   // Synchroniser and edge decode
   // ---------------------------------------------------------------
   // Only syncB feeds the detector, so metastability on syncA never reaches logic.
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         syncPrev <= 1'b0;
         edgeSeen <= 1'b0;
      end else begin
         syncA <= pinIn; // R25
         syncB <= syncA; // R25
         syncPrev <= syncB;
         case (eventSelect) // R26
            `EVT_RISING: edgeSeen <= syncB & ~syncPrev;
            `EVT_FALLING: edgeSeen <= ~syncB & syncPrev;
            `EVT_BOTH: edgeSeen <= syncB ^ syncPrev;
            default: edgeSeen <= 1'b0;
         endcase
      end
   end

endmodule // pin_edge_detect

// File: core/timer_channel.v
// One 16-bit timer channel with Avalon-MM registers, edge modes and PWM.
// Contract
// R1: Module config value 0x4 selects split mode with independent 16-bit timers.
// R2: One-shot and periodic modes count down 16 bits with optional 8-bit prescaler.
// R3: Timer mode field chooses one-shot versus periodic behaviour.
// R4: Software writes 0x1 for one-shot and 0x2 for periodic.
// R5: Setting run enable starts counting down from the preloaded value.
// R6: Cycle after zero, counter reloads from load value, prescaler from prescale.
// R7: One-shot stops and clears run enable at time-out; periodic continues.
// R8: Time-out sets sticky raw flag; mask gates masked flag and interrupt.
// R9: Writing 1 to the clear register clears raw and masked status.
// R10: Time-out pulses the converter trigger only with trigger enable set.
// R11: Writing the load value while running loads it on the next cycle.
// R12: With stall set, counting freezes while the debugger halts the processor.
// R13: Pin must hold each new level two clocks; input up to quarter clock.
// R14: Prescaler is bypassed in edge count, edge time and PWM modes.
// R15: Capture bit 0 with capture mode counts edges chosen by event select.
// R16: Software sets load minus match to the number of edges to count.
// R17: Each edge decrements by one; equality with match sets match flags.
// R18: After match, reload counter, clear run enable, ignore later edges.
// R19: Edge time mode free-runs down from load value, 0xFFFF after reset.
// R20: Each selected edge copies count to value register and sets capture flag.
// R21: Counter keeps running after capture, reloads at zero; capture holds.
// R22: PWM needs alternate select 1, capture bit 0, timer mode 0x2.
// R23: PWM counts to zero, reloads next cycle, repeats, raises no status.
// R24: PWM asserts at load value, deasserts at match; level bit inverts.
// R25: Pin input passes two synchroniser stages before edge detection.
// R26: Event select 00 rising, 01 falling, 11 both edges.
`include "timer_channel_defs.vh"

module timer_channel (
   input wire core_clk,
   input wire resetn,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire debugHalt,
   input wire pinIn,
   output reg pinOut,
   output reg pinOutEnable,
   output reg timerInterrupt,
   output reg adcTrigger
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   reg rstMeta;
   reg rstSync;

   // Asynchronous assert, synchronous release through two flops.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   reg [2:0] moduleConfig;
   reg [1:0] timerMode;
   reg captureMode;
   reg altModeSelect;
   reg runEnable;
   reg stallEnable;
   reg [1:0] eventSelect;
   reg triggerEnable;
   reg pwmLevel;
   reg [2:0] intMask;
   reg [2:0] rawStatus;
   reg [15:0] intervalLoad;
   reg [15:0] matchValue;
   reg [7:0] prescaleValue;
   reg [15:0] counter;
   reg [7:0] prescaleCount;
   reg [15:0] capturedValue;
   reg loadPending;
   reg runPrev;
   reg pwmRaw;

   wire edgeSeen;

   // Combine a 32-bit word into a register under its byte lanes.
   function [31:0] merge_bytes;
      input [31:0] oldValue;
      input [31:0] newValue;
      input [3:0] lanes;
      integer i;
      begin
         merge_bytes = oldValue;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               merge_bytes[i*8 +: 8] = newValue[i*8 +: 8];
            end
         end
      end
   endfunction

   // Mode decoding used by both the counter and the status paths.
   wire splitMode = (moduleConfig == `CFG_SPLIT); // R1
   wire modeEdgeCount = splitMode & ~altModeSelect & ~captureMode
                        & (timerMode == `TMR_CAPTURE); // R15
   wire modeEdgeTime = splitMode & ~altModeSelect & captureMode
                       & (timerMode == `TMR_CAPTURE); // R19
   wire modePwm = splitMode & altModeSelect & ~captureMode
                  & (timerMode == `TMR_PERIODIC); // R22
   wire modeTimer = splitMode & ~altModeSelect
                    & ((timerMode == `TMR_ONE_SHOT) | (timerMode == `TMR_PERIODIC)); // R3 R4
   wire frozen = stallEnable & debugHalt; // R12
   // The first run cycle only loads the counter, so a stale count raises no event.
   wire active = runEnable & runPrev & ~frozen;
   wire atZero = (counter == `COUNT_ZERO);
   wire prescaleDone = (prescaleCount == 8'h00) | ~modeTimer; // R14
   wire timeoutEvent = active & modeTimer & atZero & prescaleDone;
   wire matchEvent = active & modeEdgeCount & edgeSeen & (counter - 16'h0001 == matchValue);
   wire captureEvent = active & modeEdgeTime & edgeSeen;
   wire busWrite = write & ~waitrequest;
   wire ctlWrite = busWrite & (address == `OFS_CONTROL);
   wire [31:0] ctlWord = merge_bytes({25'h0, pwmLevel, triggerEnable, 1'b0, eventSelect,
                                      stallEnable, runEnable}, writedata, byteenable);
   wire [31:0] loadWord = merge_bytes({16'h0, intervalLoad}, writedata, byteenable);
   wire [31:0] matchWord = merge_bytes({16'h0, matchValue}, writedata, byteenable);
   wire [2:0] clearBits = (busWrite & (address == `OFS_INT_CLEAR))
                          ? writedata[2:0] & {3{byteenable[0]}} : 3'h0;

   // ---------------------------------------------------------------
   // Edge detector
   // ---------------------------------------------------------------
   pin_edge_detect edgeDetect (
      .core_clk(core_clk),
      .rstSync(rstSync),
      .pinIn(pinIn),
      .eventSelect(eventSelect),
      .edgeSeen(edgeSeen)
   );

   // ---------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------
   // Each access waits one cycle so read data comes from a register.
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (read & waitrequest) begin
            case (address)
               `OFS_MODULE_CONFIG: readdata <= {29'h0, moduleConfig};
               `OFS_CHANNEL_MODE: readdata <= {28'h0, altModeSelect, captureMode, timerMode};
               `OFS_CONTROL: readdata <= {25'h0, pwmLevel, triggerEnable, 1'b0, eventSelect,
                                          stallEnable, runEnable};
               `OFS_INT_MASK: readdata <= {29'h0, intMask};
               `OFS_RAW_INT_STATUS: readdata <= {29'h0, rawStatus};
               `OFS_MASKED_INT_STATUS: readdata <= {29'h0, rawStatus & intMask};
               `OFS_INTERVAL_LOAD: readdata <= {16'h0, intervalLoad};
               `OFS_MATCH: readdata <= {16'h0, matchValue};
               `OFS_PRESCALE: readdata <= {24'h0, prescaleValue};
               `OFS_TIMER_VALUE: readdata <= {16'h0, modeEdgeTime ? capturedValue : counter}; // R20
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Hardware clears of run enable win over a simultaneous software write.
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         moduleConfig <= 3'h0;
         timerMode <= 2'h0;
         captureMode <= 1'b0;
         altModeSelect <= 1'b0;
         runEnable <= 1'b0;
         stallEnable <= 1'b0;
         eventSelect <= `EVT_RISING;
         triggerEnable <= 1'b0;
         pwmLevel <= 1'b0;
         intMask <= 3'h0;
         intervalLoad <= `RST_LOAD; // R19
         matchValue <= 16'hffff;
         prescaleValue <= `RST_PRESCALE;
         loadPending <= 1'b0;
      end else begin
         loadPending <= 1'b0;
         if (busWrite & byteenable[0]) begin
            case (address)
               `OFS_MODULE_CONFIG: moduleConfig <= writedata[2:0]; // R1
               `OFS_CHANNEL_MODE: begin
                  timerMode <= writedata[`MODE_TMR_LO +: 2]; // R3
                  captureMode <= writedata[`MODE_CAPTURE_BIT];
                  altModeSelect <= writedata[`MODE_ALT_BIT];
               end
               `OFS_INT_MASK: intMask <= writedata[2:0];
               `OFS_PRESCALE: prescaleValue <= writedata[7:0];
               default: begin
               end
            endcase
         end
         if (busWrite & (address == `OFS_INTERVAL_LOAD)) begin
            intervalLoad <= loadWord[15:0];
            loadPending <= runEnable; // R11
         end
         if (busWrite & (address == `OFS_MATCH)) begin
            matchValue <= matchWord[15:0];
         end
         if (ctlWrite) begin
            runEnable <= ctlWord[`CTL_RUN_BIT]; // R5
            stallEnable <= ctlWord[`CTL_STALL_BIT];
            eventSelect <= ctlWord[`CTL_EVENT_LO +: 2];
            triggerEnable <= ctlWord[`CTL_TRIG_BIT];
            pwmLevel <= ctlWord[`CTL_PWML_BIT];
         end
         if ((timeoutEvent & (timerMode == `TMR_ONE_SHOT)) | matchEvent) begin
            runEnable <= 1'b0; // R7 R18
         end
      end
   end

   // ---------------------------------------------------------------
   // Counter, prescaler and capture
   // ---------------------------------------------------------------
   // Reload happens the cycle after zero so software sees the zero state once.
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         counter <= `RST_LOAD;
         prescaleCount <= `RST_PRESCALE;
         capturedValue <= `RST_LOAD;
         runPrev <= 1'b0;
      end else begin
         runPrev <= runEnable;
         if (loadPending) begin
            counter <= intervalLoad; // R11
         end else if (runEnable & ~runPrev) begin
            counter <= intervalLoad; // R5
            prescaleCount <= prescaleValue; // R5
         end else if (matchEvent) begin
            counter <= intervalLoad; // R18
         end else if (active & modeEdgeCount & edgeSeen) begin
            counter <= counter - 16'h0001; // R17
         end else if (active & (modeTimer | modeEdgeTime | modePwm)) begin
            if (atZero & prescaleDone) begin
               counter <= intervalLoad; // R6 R21 R23
               prescaleCount <= modeTimer ? prescaleValue : 8'h00; // R6 R14
            end else if (!prescaleDone) begin
               prescaleCount <= prescaleCount - 8'h01; // R2
            end else begin
               counter <= counter - 16'h0001; // R2 R19
               prescaleCount <= modeTimer ? prescaleValue : 8'h00; // R14
            end
         end
         if (captureEvent) begin
            capturedValue <= counter; // R20 R21
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags and outputs
   // ---------------------------------------------------------------
   // A set in the same cycle as a clear wins, so no event is lost.
   always @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         rawStatus <= 3'h0;
         timerInterrupt <= 1'b0;
         adcTrigger <= 1'b0;
         pwmRaw <= 1'b0;
         pinOut <= 1'b0;
         pinOutEnable <= 1'b0;
      end else begin
         rawStatus[`INT_TIMEOUT_BIT] <= timeoutEvent |
            (rawStatus[`INT_TIMEOUT_BIT] & ~clearBits[`INT_TIMEOUT_BIT]); // R8 R9
         rawStatus[`INT_MATCH_BIT] <= matchEvent |
            (rawStatus[`INT_MATCH_BIT] & ~clearBits[`INT_MATCH_BIT]); // R17 R9
         rawStatus[`INT_CAPTURE_BIT] <= captureEvent |
            (rawStatus[`INT_CAPTURE_BIT] & ~clearBits[`INT_CAPTURE_BIT]); // R20 R9
         timerInterrupt <= |(rawStatus & intMask); // R8
         adcTrigger <= timeoutEvent & triggerEnable; // R10
         if (modePwm & runEnable) begin
            if (counter == intervalLoad) begin
               pwmRaw <= 1'b1; // R24
            end else if (counter == matchValue) begin
               pwmRaw <= 1'b0; // R24
            end
         end else begin
            pwmRaw <= 1'b0;
         end
         // The pin stays low outside PWM even with the level bit set.
         pinOut <= modePwm & (pwmRaw ^ pwmLevel); // R24
         pinOutEnable <= modePwm;
      end
   end

endmodule // timer_channel

// File: inc/timer_channel_defs.vh
// Offsets, field positions, reset values and codes for the 16-bit timer channel.
`ifndef TIMER_CHANNEL_DEFS_VH
`define TIMER_CHANNEL_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_MODULE_CONFIG 6'h00
`define OFS_CHANNEL_MODE 6'h04
`define OFS_CONTROL 6'h0c
`define OFS_INT_MASK 6'h18
`define OFS_RAW_INT_STATUS 6'h1c
`define OFS_MASKED_INT_STATUS 6'h20
`define OFS_INT_CLEAR 6'h24
`define OFS_INTERVAL_LOAD 6'h28
`define OFS_MATCH 6'h30
`define OFS_PRESCALE 6'h38
`define OFS_TIMER_VALUE 6'h48

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MODE_TMR_LO 0
`define MODE_CAPTURE_BIT 2
`define MODE_ALT_BIT 3
`define CTL_RUN_BIT 0
`define CTL_STALL_BIT 1
`define CTL_EVENT_LO 2
`define CTL_TRIG_BIT 5
`define CTL_PWML_BIT 6
`define INT_TIMEOUT_BIT 0
`define INT_MATCH_BIT 1
`define INT_CAPTURE_BIT 2

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define CFG_SPLIT 3'h4
`define TMR_ONE_SHOT 2'h1
`define TMR_PERIODIC 2'h2
`define TMR_CAPTURE 2'h3
`define EVT_RISING 2'h0
`define EVT_FALLING 2'h1
`define EVT_BOTH 2'h3
`define RST_LOAD 16'hffff
`define RST_PRESCALE 8'h00
`define COUNT_ZERO 16'h0000

`endif

// File: verif/pin_source.sv
// Behavioural driver of the capture pin, toggling it a set number of times.
module pin_source (
   input wire core_clk,
   input wire start,
   input wire [3:0] edgeCount,
   output logic pinLevel,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left;
   logic [1:0] hold;
   initial begin
      pinLevel = 1'b0;
      busy = 1'b0;
   end
   // Each level stays three clocks, which keeps the pin frequency at a sixth of the clock rate, under a quarter.
   always @(posedge core_clk) begin
      if (start && !busy) begin
         left <= edgeCount;
         hold <= 2'd0;
         busy <= 1'b1;
      end else if (busy) begin
         if (hold != 2'd0) hold <= hold - 2'd1;
         else if (left == 4'd0) busy <= 1'b0;
         else begin
            pinLevel <= ~pinLevel;
            left <= left - 4'd1;
            hold <= 2'd2;
         end
      end
   end
endmodule // pin_source

// File: verif/sixteen_bit_timer_channel_tb.sv
// Self-checking bench for the 16-bit timer channel.
`include "timer_channel_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module sixteen_bit_timer_channel_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, resetn = 0, read = 0, write = 0, debugHalt = 0, pinStart = 0;
   logic [5:0] address = 0;
   logic [31:0] writedata = 0, q, q2;
   logic [3:0] byteenable = 4'hf, edgeCount = 0;
   wire [31:0] readdata;
   wire waitrequest, pinIn, pinBusy, pinOut, pinOutEnable, timerInterrupt, adcTrigger;
   int error_cnt = 0, checks_done = 0, cycles = 0, n, h;
   int expCount[3] = '{7, 7, 5};
   logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h3};
   always #10 core_clk = ~core_clk;
   timer_channel DUT (.core_clk(core_clk), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .debugHalt(debugHalt), .pinIn(pinIn), .pinOut(pinOut),
      .pinOutEnable(pinOutEnable), .timerInterrupt(timerInterrupt), .adcTrigger(adcTrigger));
   pin_source pin (.core_clk(core_clk), .start(pinStart), .edgeCount(edgeCount),
      .pinLevel(pinIn), .busy(pinBusy));
   // ---------------------------------------------------------------
   // Bus, pin and timing helpers
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // A hung bench is worse than a failed one, so every run is capped.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   // Request is held until the rising edge at which waitrequest is sampled low.
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic pins(input logic [3:0] k);
      edgeCount <= k;
      pinStart <= 1'b1;
      @(posedge core_clk);
      pinStart <= 1'b0;
      n = 0;
      do begin @(negedge core_clk); n++; end while (pinBusy !== 1'b0 && n < 100);
      repeat (6) @(posedge core_clk);
   endtask
   task automatic wait_adc(input int lim);
      n = 0;
      do begin @(negedge core_clk); n++; end while (adcTrigger !== 1'b1 && n < lim);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(`OFS_INTERVAL_LOAD); `CHK(q, 32'h0000ffff)
      rd(`OFS_TIMER_VALUE); `CHK(q, 32'h0000ffff)
      rd(`OFS_PRESCALE); `CHK(q, 32'h0)
      rd(6'h3c); `CHK(q, 32'h0)
      wr(`OFS_MODULE_CONFIG, 32'h4);
      rd(`OFS_MODULE_CONFIG); `CHK(q, 32'h4)
   endtask
   task automatic t_one_shot;
      wr(`OFS_CHANNEL_MODE, 32'h1);
      wr(`OFS_INTERVAL_LOAD, 32'h5);
      wr(`OFS_INT_MASK, 32'h1);
      wr(`OFS_CONTROL, 32'h21);
      wait_adc(40); `CHK(adcTrigger, 1'b1)
      wait_adc(30); `CHK(n, 30)
      rd(`OFS_CONTROL); `CHK(q, 32'h20)
      rd(`OFS_RAW_INT_STATUS); `CHK(q, 32'h1)
      rd(`OFS_MASKED_INT_STATUS); `CHK(q, 32'h1)
      `CHK(timerInterrupt, 1'b1)
      wr(`OFS_INT_CLEAR, 32'h1);
      rd(`OFS_RAW_INT_STATUS); `CHK(q, 32'h0)
      rd(`OFS_MASKED_INT_STATUS); `CHK(q, 32'h0)
      `CHK(timerInterrupt, 1'b0)
   endtask
   task automatic t_periodic;
      wr(`OFS_CHANNEL_MODE, 32'h2);
      wr(`OFS_PRESCALE, 32'h1);
      wr(`OFS_INTERVAL_LOAD, 32'h64);
      wr(`OFS_CONTROL, 32'h21);
      wr(`OFS_INTERVAL_LOAD, 32'h3);
      wait_adc(30); `CHK(adcTrigger, 1'b1)
      wait_adc(30); `CHK(n, 8)
      wr(`OFS_CONTROL, 32'h23);
      debugHalt <= 1'b1;
      repeat (2) @(posedge core_clk);
      wait_adc(40); `CHK(n, 40)
      @(posedge core_clk);
      debugHalt <= 1'b0;
      wait_adc(20); `CHK(adcTrigger, 1'b1)
      wr(`OFS_CONTROL, 32'h1);
      wait_adc(40); `CHK(n, 40)
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_PRESCALE, 32'h0);
      wr(`OFS_INT_CLEAR, 32'h7);
   endtask
   // Pin level alternates between passes, so rising and falling passes each count three edges.
   task automatic t_edge_count;
      wr(`OFS_CHANNEL_MODE, 32'h3);
      wr(`OFS_MATCH, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_CONTROL, {26'h0, codes[i], 2'b00});
         wr(`OFS_INTERVAL_LOAD, 32'ha);
         wr(`OFS_CONTROL, {26'h0, codes[i], 2'b01});
         pins(4'd5);
         rd(`OFS_TIMER_VALUE); `CHK(q, 32'(expCount[i]))
      end
      wr(`OFS_CONTROL, 32'h0c);
      wr(`OFS_INTERVAL_LOAD, 32'ha);
      wr(`OFS_MATCH, 32'h6);
      wr(`OFS_INT_MASK, 32'h2);
      wr(`OFS_CONTROL, 32'h0d);
      pins(4'd6);
      rd(`OFS_RAW_INT_STATUS); `CHK(q, 32'h2)
      `CHK(timerInterrupt, 1'b1)
      rd(`OFS_CONTROL); `CHK(q, 32'h0c)
      rd(`OFS_TIMER_VALUE); `CHK(q, 32'ha)
      wr(`OFS_INT_CLEAR, 32'h7);
   endtask
   task automatic t_edge_time;
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_CHANNEL_MODE, 32'h7);
      wr(`OFS_INTERVAL_LOAD, 32'hffff);
      wr(`OFS_INT_MASK, 32'h4);
      wr(`OFS_CONTROL, 32'h1);
      pins(4'd2);
      rd(`OFS_RAW_INT_STATUS); `CHK(q, 32'h4)
      rd(`OFS_TIMER_VALUE);
      q2 = q;
      `CHK(q2 > 32'hff00 && q2 < 32'hffff, 1'b1)
      repeat (20) @(posedge core_clk);
      rd(`OFS_TIMER_VALUE); `CHK(q, q2)
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_INT_CLEAR, 32'h7);
   endtask
   // Nine down to four is high, three down to zero is low.
   task automatic t_pwm;
      wr(`OFS_CHANNEL_MODE, 32'ha);
      wr(`OFS_INTERVAL_LOAD, 32'h9);
      wr(`OFS_MATCH, 32'h3);
      wr(`OFS_CONTROL, 32'h1);
      for (int lvl = 0; lvl < 2; lvl++) begin
         repeat (25) @(posedge core_clk);
         h = 0;
         repeat (10) begin @(negedge core_clk); h += (pinOut === 1'b1); end
         `CHK(h, lvl ? 4 : 6)
         `CHK(pinOutEnable, 1'b1)
         wr(`OFS_CONTROL, 32'h41);
      end
      rd(`OFS_RAW_INT_STATUS); `CHK(q, 32'h0)
      wr(`OFS_CONTROL, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_one_shot();
      t_periodic();
      t_edge_count();
      t_edge_time();
      t_pwm();
      stop_test();
   end
endmodule // sixteen_bit_timer_channel_tb
bind timer_channel timer_channel_chk chk (.core_clk(core_clk), .resetn(resetn),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .debugHalt(debugHalt), .pinIn(pinIn), .pinOut(pinOut), .pinOutEnable(pinOutEnable),
   .timerInterrupt(timerInterrupt), .adcTrigger(adcTrigger));

// File: verif/timer_channel_chk.sv
// Port-level assertions for the 16-bit timer channel.
module timer_channel_chk (
   input wire core_clk,
   input wire resetn,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire debugHalt,
   input wire pinIn,
   input wire pinOut,
   input wire pinOutEnable,
   input wire timerInterrupt,
   input wire adcTrigger
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Bus handshake, readback, pin, trigger and interrupt relations
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // The slave may only hold its answer for one cycle.
   property p_wait_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_wait_answer;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("access not answered");
   property p_wait_cause;
      $fell(waitrequest) |-> $past(read || write);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   // Registers are at most 16 bits wide, so the upper half must read zero.
   property p_upper_zero;
      read && !waitrequest |-> readdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_read_hold;
      $changed(readdata) |-> !waitrequest && $past(read);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("readdata moved");
   property p_adc_pulse;
      adcTrigger |=> !adcTrigger;
   endproperty
   a_adc_pulse: assert property (p_adc_pulse) else $error("trigger longer than one cycle");
   property p_pwm_idle;
      !pinOutEnable |-> !pinOut;
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("pin driven outside pwm");
   // Only a register write can change the pin direction.
   property p_pwm_enable;
      $changed(pinOutEnable) |-> $past(write) || $past(write, 2) || $past(write, 3);
   endproperty
   a_pwm_enable: assert property (p_pwm_enable) else $error("pin enable moved alone");
   property p_irq_clear;
      $fell(timerInterrupt) |-> $past(write) || $past(write, 2) || $past(write, 3);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt fell alone");
endmodule // timer_channel_chk
